// ---- logic/csw_pkg.sv ----
// constants and carrier types shared by the clock switch block
package csw_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int SRC_W = 3;
  localparam int DIV_W = 4;

  // ==========================================================
  // register byte addresses
  localparam logic [ADDR_W-1:0] ADR_OSC_LO = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_OSC_HI = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_REF_LO = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_REF_HI = 4'h3;

  // ==========================================================
  // unlock keys, first and second write of each byte
  localparam logic [DATA_W-1:0] KEY_HI_FIRST = 8'h78;
  localparam logic [DATA_W-1:0] KEY_HI_SECOND = 8'h9A;
  localparam logic [DATA_W-1:0] KEY_LO_FIRST = 8'h46;
  localparam logic [DATA_W-1:0] KEY_LO_SECOND = 8'h57;

  // ==========================================================
  // field positions inside each byte lane
  localparam int OSC_LO_SWEN_BIT = 0;
  localparam int OSC_LO_LOCK_BIT = 5;
  localparam int OSC_HI_NEW_LSB = 0;
  localparam int OSC_HI_CUR_LSB = 4;
  localparam int REF_HI_EN_BIT = 7;
  localparam int REF_HI_SLP_BIT = 5;
  localparam int REF_HI_SEL_BIT = 4;
  localparam int REF_HI_DIV_LSB = 0;

  // ==========================================================
  // reset values
  localparam logic [SRC_W-1:0] RST_NEW_SRC = 3'h0;
  localparam logic [SRC_W-1:0] RST_CUR_SRC = 3'h0;
  localparam logic [DIV_W-1:0] RST_DIV = 4'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } csw_bus_req_t;

  // pins from outside the clock domain, listed msb first, in sync bit order
  typedef struct packed {
    logic halfRateMode;
    logic primaryMode;
    logic sleepMode;
    logic pllLock;
    logic switchDone;
    logic primaryCrystalIn;
  } csw_pins_t;

  localparam int SY_N = 6;
  localparam int SY_PRIM = 0;
  localparam int SY_DONE = 1;
  localparam int SY_LOCK = 2;
  localparam int SY_SLEEP = 3;
  localparam int SY_PMODE = 4;
  localparam int SY_HALF = 5;

endpackage

// ---- logic/csw_unlock.sv ----
// two-key unlock detector guarding one protected register byte
`timescale 1ns/1ps
module csw_unlock #(
  parameter int DATA_W = 8,
  parameter logic [DATA_W-1:0] KEY_FIRST = 8'h00,
  parameter logic [DATA_W-1:0] KEY_SECOND = 8'h01
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic access,
  input wire logic hit,
  input wire logic [DATA_W-1:0] wdata,
  output logic open
);

  // ==========================================================
  // elaboration checks
  if (DATA_W < 1) begin : g_chk_w
    $error("csw_unlock: DATA_W must be at least 1");
  end
  if (KEY_FIRST == KEY_SECOND) begin : g_chk_k
    $error("csw_unlock: the two keys must differ");
  end

  typedef struct packed {
    logic armed;
    logic open;
  } csw_ulk_state_t;

  csw_ulk_state_t st_r;
  csw_ulk_state_t st_nxt;

  // ==========================================================
  // every bus access advances the sequence; idle cycles do not,
  // so any other access between the keys breaks it
  always_comb begin
    st_nxt = st_r;
    if (access) begin
      st_nxt.armed = hit && (wdata == KEY_FIRST);
      st_nxt.open = st_r.armed && hit && (wdata == KEY_SECOND);
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign open = st_r.open;

endmodule

// ---- logic/csw_refdiv.sv ----
// reference clock divider with period-boundary code reload
`timescale 1ns/1ps
module csw_refdiv #(
  parameter int DIV_W = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic tick,
  input wire logic [DIV_W-1:0] divSel,
  output logic clkOut
);

  if (DIV_W < 1 || DIV_W > 8) begin : g_chk
    $error("csw_refdiv: DIV_W must lie between 1 and 8");
  end

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] code;
    logic level;
  } csw_div_state_t;

  csw_div_state_t st_r;
  csw_div_state_t st_nxt;

  // ==========================================================
  // each half period lasts code+1 ticks; a new code is taken only
  // at the end of a high half or while stopped, so no period mixes two codes
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      // stop forces low at once: the source may already be halted
      st_nxt.level = 1'b0;
      st_nxt.cnt = '0;
      st_nxt.code = divSel;
    end else if (tick) begin
      if (st_r.cnt == st_r.code) begin
        st_nxt.cnt = '0;
        st_nxt.level = !st_r.level;
        if (!st_r.level) begin
          st_nxt.code = st_r.code;
        end
        if (st_r.level) begin
          st_nxt.code = divSel;
        end
      end else begin
        st_nxt.cnt = DIV_W'(st_r.cnt + 1'b1);
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clkOut = st_r.level;

endmodule

// ---- logic/csw_top.sv ----
// oscillator switch request path and reference clock output
`timescale 1ns/1ps
module csw_top (
  input wire logic clk,
  input wire logic nrst,
  input csw_pkg::csw_bus_req_t busReq,
  input csw_pkg::csw_pins_t pins,
  output logic [csw_pkg::DATA_W-1:0] rdData,
  output logic switchRequest,
  output logic [csw_pkg::SRC_W-1:0] switchTarget,
  output logic [csw_pkg::SRC_W-1:0] currentSource,
  output logic halfRateClockOut,
  output logic refClockPin,
  output logic refClockPinOe_n,
  output logic primaryOscPowerDown
);

  // ==========================================================
  // state of the block, registered as one word
  typedef struct packed {
    logic [csw_pkg::SY_N-1:0] sync1;
    logic [csw_pkg::SY_N-1:0] sync2;
    logic donePrev;
    logic primPrev;
    logic [csw_pkg::SRC_W-1:0] newSource;
    logic [csw_pkg::SRC_W-1:0] curSource;
    logic swEnable;
    logic refEnable;
    logic refSleepRun;
    logic refSourceSel;
    logic [csw_pkg::DIV_W-1:0] refDivSel;
    logic [csw_pkg::DATA_W-1:0] rdata;
    logic halfClk;
    logic oscPowerDown;
    logic pinOe_n;
  } csw_state_t;

  csw_state_t st_r;
  csw_state_t st_nxt;

  // ==========================================================
  // elaboration checks on the shared constants: a field that
  // spills out of its byte or lands on a neighbour would corrupt
  // both the write decode and the read-back without a warning
  if ($bits(csw_pkg::csw_pins_t) != csw_pkg::SY_N) begin : g_chk_sync
    $error("csw_top: synchroniser width differs from the pin group");
  end
  if (csw_pkg::SY_PRIM >= csw_pkg::SY_N ||
      csw_pkg::SY_DONE >= csw_pkg::SY_N ||
      csw_pkg::SY_LOCK >= csw_pkg::SY_N ||
      csw_pkg::SY_SLEEP >= csw_pkg::SY_N ||
      csw_pkg::SY_PMODE >= csw_pkg::SY_N ||
      csw_pkg::SY_HALF >= csw_pkg::SY_N) begin : g_chk_sy_idx
    $error("csw_top: a pin index lies outside the synchroniser");
  end
  if (csw_pkg::OSC_HI_NEW_LSB + csw_pkg::SRC_W >
      csw_pkg::OSC_HI_CUR_LSB) begin : g_chk_hi_new
    $error("csw_top: new and current source fields overlap");
  end
  if (csw_pkg::OSC_HI_CUR_LSB + csw_pkg::SRC_W >
      csw_pkg::DATA_W) begin : g_chk_hi_cur
    $error("csw_top: current source field leaves the byte");
  end
  if (csw_pkg::OSC_LO_SWEN_BIT >= csw_pkg::DATA_W ||
      csw_pkg::OSC_LO_LOCK_BIT >= csw_pkg::DATA_W) begin : g_chk_lo_bits
    $error("csw_top: a low byte status bit lies outside the byte");
  end
  if (csw_pkg::OSC_LO_SWEN_BIT ==
      csw_pkg::OSC_LO_LOCK_BIT) begin : g_chk_lo_eq
    $error("csw_top: switch enable and lock status share a bit");
  end
  if (csw_pkg::REF_HI_DIV_LSB + csw_pkg::DIV_W >
      csw_pkg::REF_HI_SEL_BIT) begin : g_chk_div
    $error("csw_top: divider field runs into the select bit");
  end
  if (csw_pkg::REF_HI_EN_BIT == csw_pkg::REF_HI_SLP_BIT ||
      csw_pkg::REF_HI_EN_BIT == csw_pkg::REF_HI_SEL_BIT ||
      csw_pkg::REF_HI_SLP_BIT == csw_pkg::REF_HI_SEL_BIT) begin : g_chk_ref
    $error("csw_top: two reference control bits share a position");
  end
  if (csw_pkg::REF_HI_EN_BIT >= csw_pkg::DATA_W) begin : g_chk_ref_en
    $error("csw_top: reference enable bit lies outside the byte");
  end
  if (csw_pkg::ADR_OSC_LO == csw_pkg::ADR_OSC_HI ||
      csw_pkg::ADR_OSC_LO == csw_pkg::ADR_REF_HI ||
      csw_pkg::ADR_OSC_HI == csw_pkg::ADR_REF_HI) begin : g_chk_adr
    $error("csw_top: two register bytes share an address");
  end

  // ==========================================================
  // bus decode
  logic access;
  logic wrOscLo;
  logic wrOscHi;
  logic wrRefHi;
  logic openLo;
  logic openHi;
  logic refLevel;

  // reads and writes alike count as one instruction each
  assign access = busReq.wr || busReq.rd;
  assign wrOscLo = busReq.wr && (busReq.addr == csw_pkg::ADR_OSC_LO);
  assign wrOscHi = busReq.wr && (busReq.addr == csw_pkg::ADR_OSC_HI);
  assign wrRefHi = busReq.wr && (busReq.addr == csw_pkg::ADR_REF_HI);

  // ==========================================================
  // key detectors for the two protected bytes
  // a key pair opens its byte for the next access only; the
  // opening survives idle cycles but not a read or another write
  csw_unlock #(
    .DATA_W(csw_pkg::DATA_W),
    .KEY_FIRST(csw_pkg::KEY_HI_FIRST),
    .KEY_SECOND(csw_pkg::KEY_HI_SECOND)
  ) u_unlock_hi (
    .clk(clk),
    .nrst(nrst),
    .access(access),
    .hit(wrOscHi),
    .wdata(busReq.wdata),
    .open(openHi)
  );

  csw_unlock #(
    .DATA_W(csw_pkg::DATA_W),
    .KEY_FIRST(csw_pkg::KEY_LO_FIRST),
    .KEY_SECOND(csw_pkg::KEY_LO_SECOND)
  ) u_unlock_lo (
    .clk(clk),
    .nrst(nrst),
    .access(access),
    .hit(wrOscLo),
    .wdata(busReq.wdata),
    .open(openLo)
  );

  // ==========================================================
  // synchronised pin views, read from the second stage only;
  // every pin reaches the logic two edges late and an edge found
  // on it acts one edge after that, so a done pulse shorter than
  // one clock period may be missed entirely
  logic primSy;
  logic doneSy;
  logic lockSy;
  logic sleepSy;
  logic pmodeSy;
  logic halfSy;
  logic doneRise;
  logic primRise;
  logic sleepRunOk;
  logic refRun;
  logic refTick;

  assign primSy = st_r.sync2[csw_pkg::SY_PRIM];
  assign doneSy = st_r.sync2[csw_pkg::SY_DONE];
  assign lockSy = st_r.sync2[csw_pkg::SY_LOCK];
  assign sleepSy = st_r.sync2[csw_pkg::SY_SLEEP];
  assign pmodeSy = st_r.sync2[csw_pkg::SY_PMODE];
  assign halfSy = st_r.sync2[csw_pkg::SY_HALF];
  assign doneRise = doneSy && !st_r.donePrev;
  assign primRise = primSy && !st_r.primPrev;

  // ==========================================================
  // reference source and sleep gating
  // stopping is immediate, so disabling may shorten the last high
  // half; changing the code never does, it waits for a period end
  // the sleep path needs both bits and a primary oscillator mode
  assign sleepRunOk = st_r.refSleepRun && st_r.refSourceSel && pmodeSy;
  // with the enable clear the divider stops and the pin is released
  assign refRun = st_r.refEnable && (!sleepSy || sleepRunOk);
  // the primary crystal is sampled at the system rate, so it must
  // run well below half of clk for its edges to be seen
  assign refTick = st_r.refSourceSel ? primRise : 1'b1;

  csw_refdiv #(
    .DIV_W(csw_pkg::DIV_W)
  ) u_refdiv (
    .clk(clk),
    .nrst(nrst),
    .run(refRun),
    .tick(refTick),
    .divSel(st_r.refDivSel),
    .clkOut(refLevel)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    st_nxt = st_r;

    // two-stage synchronisers and edge history
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.donePrev = doneSy;
    st_nxt.primPrev = primSy;

    // new source only in the access right after the high keys
    if (wrOscHi && openHi) begin
      st_nxt.newSource =
        busReq.wdata[csw_pkg::OSC_HI_NEW_LSB +: csw_pkg::SRC_W];
    end

    // a finished switch adopts the target and drops the request;
    // a done edge seen with no request pending is ignored, so a
    // stray edge from the clock mux cannot change the source
    if (doneRise && st_r.swEnable) begin
      st_nxt.curSource = st_r.newSource;
      st_nxt.swEnable = 1'b0;
    end

    // software set is placed after the clear so that it wins
    if (wrOscLo && openLo) begin
      st_nxt.swEnable = busReq.wdata[csw_pkg::OSC_LO_SWEN_BIT];
    end

    // reference control has no key
    if (wrRefHi) begin
      st_nxt.refEnable = busReq.wdata[csw_pkg::REF_HI_EN_BIT];
      st_nxt.refSleepRun = busReq.wdata[csw_pkg::REF_HI_SLP_BIT];
      st_nxt.refSourceSel = busReq.wdata[csw_pkg::REF_HI_SEL_BIT];
      st_nxt.refDivSel =
        busReq.wdata[csw_pkg::REF_HI_DIV_LSB +: csw_pkg::DIV_W];
    end

    // read data live for exactly one cycle; unmapped reads give zero
    // the lock bit is the live synchronised pin, not a stored copy
    st_nxt.rdata = '0;
    if (busReq.rd) begin
      case (busReq.addr)
        csw_pkg::ADR_OSC_LO: begin
          st_nxt.rdata[csw_pkg::OSC_LO_SWEN_BIT] = st_r.swEnable;
          st_nxt.rdata[csw_pkg::OSC_LO_LOCK_BIT] = lockSy;
        end
        csw_pkg::ADR_OSC_HI: begin
          st_nxt.rdata[csw_pkg::OSC_HI_NEW_LSB +: csw_pkg::SRC_W] =
            st_r.newSource;
          st_nxt.rdata[csw_pkg::OSC_HI_CUR_LSB +: csw_pkg::SRC_W] =
            st_r.curSource;
        end
        csw_pkg::ADR_REF_HI: begin
          st_nxt.rdata[csw_pkg::REF_HI_EN_BIT] = st_r.refEnable;
          st_nxt.rdata[csw_pkg::REF_HI_SLP_BIT] = st_r.refSleepRun;
          st_nxt.rdata[csw_pkg::REF_HI_SEL_BIT] = st_r.refSourceSel;
          st_nxt.rdata[csw_pkg::REF_HI_DIV_LSB +: csw_pkg::DIV_W] =
            st_r.refDivSel;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end

    // half-rate clock toggles every cycle while its mode is on
    st_nxt.halfClk = halfSy ? !st_r.halfClk : 1'b0;

    // primary oscillator stays up in sleep whenever sleepRunOk holds, even with the reference enable clear
    st_nxt.oscPowerDown = sleepSy && !sleepRunOk;

    // pad driven (enable low) only while the reference runs
    st_nxt.pinOe_n = !refRun;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.newSource <= csw_pkg::RST_NEW_SRC;
      st_r.curSource <= csw_pkg::RST_CUR_SRC;
      st_r.refDivSel <= csw_pkg::RST_DIV;
      st_r.pinOe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, each from a flip-flop
  // the pad enable and the divider level move on the same edge,
  // so the pin is never released while still driven high
  assign rdData = st_r.rdata;
  assign switchRequest = st_r.swEnable;
  assign switchTarget = st_r.newSource;
  assign currentSource = st_r.curSource;
  assign halfRateClockOut = st_r.halfClk;
  assign refClockPin = refLevel;
  assign refClockPinOe_n = st_r.pinOe_n;
  assign primaryOscPowerDown = st_r.oscPowerDown;

endmodule

// ---- verification/csw_top_monitor.sv ----
// assertion checker bound to the clock switch top ports
`timescale 1ns/1ps
module csw_top_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire csw_pkg::csw_bus_req_t busReq,
  input wire csw_pkg::csw_pins_t pins,
  input wire logic [csw_pkg::DATA_W-1:0] rdData,
  input wire logic switchRequest,
  input wire logic [csw_pkg::SRC_W-1:0] switchTarget,
  input wire logic [csw_pkg::SRC_W-1:0] currentSource,
  input wire logic halfRateClockOut,
  input wire logic refClockPin,
  input wire logic refClockPinOe_n,
  input wire logic primaryOscPowerDown
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // key sequences: one access per cycle, no gap allowed here
  sequence wrTo(a, d);
    busReq.wr && busReq.addr == a && busReq.wdata == d;
  endsequence
  sequence hiOpen;
    wrTo(csw_pkg::ADR_OSC_HI, csw_pkg::KEY_HI_FIRST) ##1
    wrTo(csw_pkg::ADR_OSC_HI, csw_pkg::KEY_HI_SECOND) ##1
    busReq.wr && busReq.addr == csw_pkg::ADR_OSC_HI;
  endsequence
  sequence loOpen;
    wrTo(csw_pkg::ADR_OSC_LO, csw_pkg::KEY_LO_FIRST) ##1
    wrTo(csw_pkg::ADR_OSC_LO, csw_pkg::KEY_LO_SECOND) ##1
    busReq.wr && busReq.addr == csw_pkg::ADR_OSC_LO;
  endsequence
  hi_unlock_a: assert property (
    hiOpen |=> switchTarget == $past(busReq.wdata[2:0]))
    else $error("new source not taken after unlock");
  lo_unlock_a: assert property (
    loOpen |=> switchRequest == $past(busReq.wdata[0]))
    else $error("switch enable not taken after unlock");
  tgt_guard_a: assert property (
    !$stable(switchTarget) |->
      $past(busReq.wr && busReq.addr == csw_pkg::ADR_OSC_HI))
    else $error("source changed without a high byte write");
  done_clear_a: assert property (
    $fell(switchRequest) && !$past(busReq.wr) |->
      currentSource == $past(switchTarget))
    else $error("enable cleared without taking the target");
  half_toggle_a: assert property (
    halfRateClockOut |=> !halfRateClockOut)
    else $error("half rate clock high two cycles");
  half_off_a: assert property (
    !pins.halfRateMode [*5] |-> !halfRateClockOut)
    else $error("half rate clock runs outside its mode");
  oe_quiet_a: assert property (
    refClockPinOe_n |-> !refClockPin)
    else $error("reference pin high while not driven");
  sleep_pd_a: assert property (
    primaryOscPowerDown |-> refClockPinOe_n)
    else $error("reference driven while oscillator is off");
endmodule

bind csw_top csw_top_monitor mon_u (.clk, .nrst, .busReq, .pins,
  .rdData, .switchRequest, .switchTarget, .currentSource,
  .halfRateClockOut, .refClockPin, .refClockPinOe_n,
  .primaryOscPowerDown);

// ---- verification/csw_ref_load.sv ----
// crystal source and external load hung on the reference pin
`timescale 1ns/1ps
module csw_ref_load #(
  parameter int HALF_NS = 100
) (
  input wire logic refClockPin,
  input wire logic refClockPinOe_n,
  output logic xtal,
  output logic lineLvl
);
  logic lastLvl;
  // ==========================================================
  // free crystal, offset so its edges never meet a clk edge
  initial begin
    xtal = 1'b0;
    #7;
    forever #(HALF_NS) xtal = ~xtal;
  end
  // a released pin shows no stale level: the load sees its inverse
  always @(refClockPin or refClockPinOe_n) begin
    if (!refClockPinOe_n) begin
      lastLvl = refClockPin;
    end
  end
  assign lineLvl = refClockPinOe_n ? ~lastLvl : refClockPin;
endmodule

// ---- verification/test_clock_switch_and_ref_clock_out.sv ----
// self-checking bench for the clock switch block
`timescale 1ns/1ps
module test_clock_switch_and_ref_clock_out;
  logic clk;
  logic nrst;
  csw_pkg::csw_bus_req_t busReq;
  csw_pkg::csw_pins_t pins;
  logic hrm, pmode, slp, lock, done, xtal, lineLvl;
  logic swReq, hrOut, refPin, refOe_n, pd;
  logic [7:0] rdData;
  logic [2:0] tgt, cur;
  int n_errors, cmp_count, cyc;
  assign pins = '{hrm, pmode, slp, lock, done, xtal};
  csw_top dut_u (.clk, .nrst, .busReq, .pins, .rdData,
    .switchRequest(swReq), .switchTarget(tgt), .currentSource(cur),
    .halfRateClockOut(hrOut), .refClockPin(refPin),
    .refClockPinOe_n(refOe_n), .primaryOscPowerDown(pd));
  csw_ref_load load_u (.refClockPin(refPin),
    .refClockPinOe_n(refOe_n), .xtal, .lineLvl);
  // ==========================================================
  // clock and hang guard, the run needs about a thousand cycles
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // bus master: strobes land just after an edge, one cycle each
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{a, d, 1'b1, 1'b0};
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
    d = rdData;
  endtask
  task automatic idle(input int n);
    @(posedge clk);
    busReq <= '0;
    repeat (n) @(posedge clk);
  endtask
  task automatic keyed(input logic [3:0] a, input logic [7:0] d);
    if (a == csw_pkg::ADR_OSC_HI) begin
      wr(a, csw_pkg::KEY_HI_FIRST);
      wr(a, csw_pkg::KEY_HI_SECOND);
    end else begin
      wr(a, csw_pkg::KEY_LO_FIRST);
      wr(a, csw_pkg::KEY_LO_SECOND);
    end
    wr(a, d);
    idle(4);
  endtask
  // period of the load's view, in clk cycles, after a code settles
  task automatic per(output logic [7:0] n);
    time t0;
    idle(0);
    @(posedge lineLvl);
    @(posedge lineLvl);
    t0 = $time;
    @(posedge lineLvl);
    n = 8'(($time - t0) / 20);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_keys();
    logic [7:0] d;
    keyed(csw_pkg::ADR_OSC_HI, 8'h05);
    chk({5'h00, tgt}, 8'h05);
    wr(csw_pkg::ADR_OSC_HI, 8'h03);
    wr(csw_pkg::ADR_OSC_HI, csw_pkg::KEY_HI_FIRST);
    rd(csw_pkg::ADR_OSC_HI, d);
    wr(csw_pkg::ADR_OSC_HI, csw_pkg::KEY_HI_SECOND);
    wr(csw_pkg::ADR_OSC_HI, 8'h06);
    wr(csw_pkg::ADR_OSC_LO, 8'h01);
    wr(csw_pkg::ADR_REF_LO, 8'hFF);
    idle(4);
    chk({swReq, 4'h0, tgt}, 8'h05);
    rd(csw_pkg::ADR_OSC_HI, d);
    chk(d, 8'h05);
    rd(csw_pkg::ADR_REF_LO, d);
    chk(d, 8'h00);
  endtask
  task automatic t_switch();
    logic [7:0] d;
    lock <= 1'b1;
    keyed(csw_pkg::ADR_OSC_LO, 8'h01);
    chk({7'h00, swReq}, 8'h01);
    done <= 1'b1;
    idle(6);
    done <= 1'b0;
    rd(csw_pkg::ADR_OSC_LO, d);
    chk(d, 8'h20);
    chk({5'h00, cur}, 8'h05);
    lock <= 1'b0;
    keyed(csw_pkg::ADR_OSC_LO, 8'h01);
    idle(6);
    rd(csw_pkg::ADR_OSC_LO, d);
    chk(d, 8'h01);
    keyed(csw_pkg::ADR_OSC_LO, 8'h00);
    chk({7'h00, swReq}, 8'h00);
  endtask
  task automatic t_ref();
    logic [7:0] n;
    logic [7:0] d;
    for (int c = 0; c < 16; c++) begin
      wr(csw_pkg::ADR_REF_HI, 8'h80 | 8'(c));
      per(n);
      chk(n, 8'(2 * (c + 1)));
    end
    chk({7'h00, refOe_n}, 8'h00);
    wr(csw_pkg::ADR_REF_HI, 8'h90);
    per(n);
    chk(n, 8'h14);
    rd(csw_pkg::ADR_REF_HI, d);
    chk(d, 8'h90);
    wr(csw_pkg::ADR_REF_HI, 8'h00);
    idle(4);
    chk({6'h00, refOe_n, refPin}, 8'h02);
  endtask
  task automatic t_sleep();
    pmode <= 1'b1;
    slp <= 1'b1;
    wr(csw_pkg::ADR_REF_HI, 8'hB0);
    idle(6);
    chk({6'h00, pd, refOe_n}, 8'h00);
    wr(csw_pkg::ADR_REF_HI, 8'hA0);
    idle(6);
    chk({6'h00, pd, refOe_n}, 8'h03);
    wr(csw_pkg::ADR_REF_HI, 8'h90);
    idle(6);
    chk({6'h00, pd, refOe_n}, 8'h03);
    pmode <= 1'b0;
    wr(csw_pkg::ADR_REF_HI, 8'hB0);
    idle(6);
    chk({6'h00, pd, refOe_n}, 8'h03);
    slp <= 1'b0;
    idle(6);
    chk({6'h00, pd, refOe_n}, 8'h00);
  endtask
  task automatic t_half();
    logic a;
    hrm <= 1'b1;
    idle(6);
    a = hrOut;
    @(posedge clk);
    chk({7'h00, a ^ hrOut}, 8'h01);
    hrm <= 1'b0;
    idle(6);
    chk({7'h00, hrOut}, 8'h00);
  endtask
  // reset for three cycles, then every scenario in turn
  initial begin
    nrst = 1'b0;
    busReq = '0;
    {hrm, pmode, slp, lock, done} = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({swReq, tgt, cur, pd}, 8'h00);
    chk({7'h00, refOe_n}, 8'h01);
    t_keys();
    t_switch();
    t_ref();
    t_sleep();
    t_half();
    report_and_stop();
  end
endmodule
